/* File: include/secr_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the command register
// Assumes: Included by its bare name
// Notes:   Word offsets are byte addresses on the APB
`ifndef SECR_DEFINES_SVH
`define SECR_DEFINES_SVH

`define SECR_OFS_CMD_W0       12'h000
`define SECR_OFS_CMD_W1       12'h004
`define SECR_OFS_CMD_W2       12'h008
`define SECR_OFS_STATUS       12'h00C

`define SECR_BIT_SOFT_RESET   0
`define SECR_BIT_OUT_ENABLE   1
`define SECR_POS_TABLE_SIZE   2
`define SECR_POS_HIT_DELAY    4
`define SECR_BIT_CASC_TAIL    7
`define SECR_BIT_SRAM_TAIL    8
`define SECR_POS_PART_CFG     9
`define SECR_USED_BITS        25

`define SECR_RST_TABLE_SIZE   2'h1
`define SECR_RST_HIT_DELAY    3'h0
`define SECR_RST_CMD          72'h000000000000000004

`define SECR_SOFT_RESET_CYC   4'h8
`define SECR_SRAM_IDLE_ADDR   24'hFFFFFF

`define SECR_LAT_1DEV         4'h4
`define SECR_LAT_8DEV         4'h5
`define SECR_LAT_31DEV        4'h6

`define SECR_STS_BASE_LAT     0
`define SECR_STS_TOTAL_LAT    4
`define SECR_STS_RESET_BUSY   8
`define SECR_STS_BAD_SIZE     9

`endif

/* File: include/secr_pkg.sv */
// Purpose: Types shared by the command register block
// Assumes: Nothing
// Notes:   Constants live in secr_defines.svh
package secr_pkg;
  typedef logic [71:0] secr_cmd_type;
  typedef logic [3:0]  secr_lat_type;
  typedef enum logic [1:0] {
    SECR_PART_72,
    SECR_PART_144,
    SECR_PART_288,
    SECR_PART_SLEEP
  } secr_part_mode_type;
endpackage : secr_pkg

/* File: logic/secr_delay_line.sv */
// Purpose: Flop delay line with a selectable tap
// Assumes: tap = delay in cycles minus one
// Notes:   Taps beyond the last stage clamp to it
`timescale 1ns/10ps
module secr_delay_line #(
  parameter int W     = 1,
  parameter int DEPTH = 13
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          clr,
  // Data
  input  wire logic [W-1:0]  din,
  input  wire logic [3:0]    tap,
  output logic      [W-1:0]  dout
);
  logic [W-1:0] stage_ff [DEPTH];
  wire  [3:0]   tap_lim = (tap > 4'(DEPTH - 1)) ? 4'(DEPTH - 1) : tap;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stage
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          stage_ff[g] <= '0;
        end else if (clr) begin
          stage_ff[g] <= '0;
        end else begin
          stage_ff[g] <= (g == 0) ? din : stage_ff[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  assign dout = stage_ff[tap_lim];
endmodule : secr_delay_line

/* File: logic/secr_command_reg.sv */
// Purpose: Command and configuration register of a cascadable search device, with its effects
// Assumes: APB slave, zero wait states; datapath events arrive as one-cycle requests
// Notes:   The 72-bit register spans three APB words; the third word is all reserved
//
// Overview of operation
// - Writing soft reset starts eight-cycle internal reset
// - Soft reset bit clears after the pulse
// - Disabled: SRAM bus and hit outputs undriven
// - Disabled: cascade outputs zero, data bus input
// - Normal speed: table size gives latency 4/5/6
// - High speed: table size gives latency 5/6
// - Latency applies to searches and SRAM accesses
// - Hit delay field adds 0-7 cycles
// - Cascade tail drives misses as flag0 valid1
// - Cascade tail drives idle cycles as zero
// - SRAM tail drives idle bus ones, strobes high
// - Only SRAM tail drives the output-enable strobe
// - Eight partitions, two-bit width or sleep code
// - Partition codes in consecutive slices from bit 9
// - Register is 72 bits, top bits reserved
`timescale 1ns/10ps
`include "secr_defines.svh"
module secr_command_reg #(
  parameter int DELAY_DEPTH = 13,
  parameter int SRAM_AW     = 24
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Device strap
  input  wire logic                   high_speed,
  // Search datapath
  input  wire logic                   search_req,
  input  wire logic                   search_local_hit,
  output logic                        hit_flag,
  output logic                        hit_flag_oe,
  output logic                        hit_valid,
  output logic                        hit_valid_oe,
  // Local SRAM access requests
  input  wire logic                   sram_req,
  input  wire logic                   sram_we,
  input  wire logic [SRAM_AW-1:0]     sram_addr,
  input  wire logic                   peer_sram_drive,
  input  wire logic                   peer_sram_read,
  output logic                        sram_ack,
  // SRAM bus
  output logic      [SRAM_AW-1:0]     sram_addr_out,
  output logic                        sram_addr_oe,
  output logic                        sram_ce_n,
  output logic                        sram_we_n,
  output logic                        sram_ale_n,
  output logic                        sram_strobe_oe,
  output logic                        sram_oe_n,
  output logic                        sram_oe_n_oe,
  // Cascade link and data bus
  input  wire logic [1:0]             cascade_local_req,
  input  wire logic [2:0]             cascade_block_req,
  output logic      [1:0]             cascade_local_out,
  output logic      [2:0]             cascade_block_out,
  input  wire logic                   dq_drive_req,
  output logic                        dq_oe,
  // Configuration to the array
  output secr_pkg::secr_part_mode_type part_mode [8],
  output logic      [7:0]             part_sleep,
  output logic                        soft_reset_busy
);
  import secr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : strb_merge

  // Reserved code 11 falls back to the deepest latency so a misprogrammed part stays slow
  function automatic secr_lat_type base_latency(input logic hs, input logic [1:0] size);
    secr_lat_type r;
    r = `SECR_LAT_31DEV;
    if (!hs) begin
      case (size)
        2'h0:    r = `SECR_LAT_1DEV;
        2'h1:    r = `SECR_LAT_8DEV;
        default: r = `SECR_LAT_31DEV;
      endcase
    end else begin
      case (size)
        2'h0:    r = `SECR_LAT_8DEV;
        2'h1:    r = `SECR_LAT_8DEV;
        default: r = `SECR_LAT_31DEV;
      endcase
    end
    return r;
  endfunction : base_latency

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic [`SECR_USED_BITS-1:0] cmd_ff;
  logic [`SECR_USED_BITS-1:0] nxt_cmd;
  logic [3:0]                 rst_cnt_ff;
  logic [3:0]                 nxt_rst_cnt;

  wire apb_access  = psel & penable;
  wire apb_wr      = apb_access & pwrite;
  wire hit_w0      = (paddr == `SECR_OFS_CMD_W0);
  wire hit_w1      = (paddr == `SECR_OFS_CMD_W1);
  wire hit_w2      = (paddr == `SECR_OFS_CMD_W2);
  wire hit_sts     = (paddr == `SECR_OFS_STATUS);
  wire addr_mapped = hit_w0 | hit_w1 | hit_w2 | hit_sts;
  wire in_reset    = (rst_cnt_ff != 4'h0);

  assign pready  = 1'b1;
  assign pslverr = apb_access & ~addr_mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // Command register and soft reset

  wire [31:0] w0_merged = strb_merge({7'h00, cmd_ff}, pwdata, pstrb);
  wire        w0_write  = apb_wr & hit_w0 & ~in_reset;
  wire        soft_reset_bit_go   = w0_write & w0_merged[`SECR_BIT_SOFT_RESET];

  // Reserved bits 71:25 have no storage, so words 1 and 2 drop writes
  assign nxt_cmd = (in_reset | soft_reset_bit_go) ? `SECR_USED_BITS'(`SECR_RST_CMD)
                 : w0_write            ? {w0_merged[`SECR_USED_BITS-1:1], 1'b0}
                 : cmd_ff;

  // Count runs eight cycles; the stored bit itself never holds the one
  assign nxt_rst_cnt = soft_reset_bit_go  ? `SECR_SOFT_RESET_CYC
                     : in_reset ? rst_cnt_ff - 4'h1
                     : 4'h0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_ff     <= `SECR_USED_BITS'(`SECR_RST_CMD);
      rst_cnt_ff <= 4'h0;
    end else begin
      cmd_ff     <= nxt_cmd;
      rst_cnt_ff <= nxt_rst_cnt;
    end
  end

  assign soft_reset_busy = in_reset;

  wire       out_en     = cmd_ff[`SECR_BIT_OUT_ENABLE];
  wire [1:0] table_size = cmd_ff[`SECR_POS_TABLE_SIZE +: 2];
  wire [2:0] hit_delay  = cmd_ff[`SECR_POS_HIT_DELAY +: 3];
  wire       casc_tail  = cmd_ff[`SECR_BIT_CASC_TAIL];
  wire       sram_tail  = cmd_ff[`SECR_BIT_SRAM_TAIL];

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  wire secr_lat_type lat_base  = base_latency(high_speed, table_size);
  wire secr_lat_type lat_total = lat_base + {1'b0, hit_delay};
  wire               bad_size  = (table_size == 2'h3) | (high_speed & (table_size == 2'h0));

  wire [31:0] sts_word = ({28'h0, lat_base} << `SECR_STS_BASE_LAT)
                       | ({28'h0, lat_total} << `SECR_STS_TOTAL_LAT)
                       | ({31'h0, in_reset} << `SECR_STS_RESET_BUSY)
                       | ({31'h0, bad_size} << `SECR_STS_BAD_SIZE);

  // Soft reset bit reads one while the pulse runs, zero once it completes
  wire [31:0] w0_word  = {7'h00, cmd_ff[`SECR_USED_BITS-1:1], in_reset};
  wire [31:0] rd_word  = hit_w0  ? w0_word
                       : hit_sts ? sts_word
                       : 32'h0000_0000;

  // Captured in the setup phase so the access phase presents a settled word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Partition configuration

  genvar p;
  generate
    for (p = 0; p < 8; p++) begin : g_part
      wire [1:0] code = cmd_ff[`SECR_POS_PART_CFG + 2*p +: 2];
      assign part_mode[p]  = secr_part_mode_type'(code);
      assign part_sleep[p] = (code == 2'h3);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Latency pipelines

  // Latency follows the register live; software must not change it mid-traffic
  wire [3:0] tap_hit  = lat_total - 4'h1;
  wire [3:0] tap_sram = lat_base - 4'h1;

  wire [2:0] hit_pipe_out;
  wire       d_search = hit_pipe_out[0];
  wire       d_hit    = hit_pipe_out[1];
  wire       d_rdack  = hit_pipe_out[2];

  secr_delay_line #(
    .W     (3),
    .DEPTH (DELAY_DEPTH)
  ) u_hit_pipe (
    .clk  (clk),
    .rstn (rstn),
    .clr  (in_reset),
    .din  ({sram_req & ~sram_we, search_req & search_local_hit, search_req}),
    .tap  (tap_hit),
    .dout (hit_pipe_out)
  );

  wire [SRAM_AW+1:0] sram_pipe_out;
  wire               d_sram_req  = sram_pipe_out[0];
  wire               d_sram_we   = sram_pipe_out[1];
  wire [SRAM_AW-1:0] d_sram_addr = sram_pipe_out[SRAM_AW+1:2];

  secr_delay_line #(
    .W     (SRAM_AW + 2),
    .DEPTH (DELAY_DEPTH)
  ) u_sram_pipe (
    .clk  (clk),
    .rstn (rstn),
    .clr  (in_reset),
    .din  ({sram_addr, sram_we, sram_req}),
    .tap  (tap_sram),
    .dout (sram_pipe_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Hit outputs

  wire local_win = d_search & d_hit;
  // A non-tail device lets the line float unless it wins
  assign hit_flag_oe  = out_en & (casc_tail | local_win);
  assign hit_valid_oe = hit_flag_oe;
  assign hit_flag     = out_en & local_win;
  assign hit_valid    = out_en & d_search & (local_win | casc_tail);

  // Writes acknowledge at the base latency, reads with the extra hit delay
  assign sram_ack = out_en & ((d_sram_req & d_sram_we) | d_rdack);

  ////////////////////////////////////////////////////////////////////////////////
  // SRAM bus

  wire local_drive = out_en & d_sram_req;
  wire idle_drive  = out_en & sram_tail & ~d_sram_req & ~peer_sram_drive;

  assign sram_addr_oe   = local_drive | idle_drive;
  assign sram_strobe_oe = local_drive | idle_drive;
  assign sram_addr_out  = local_drive ? d_sram_addr : SRAM_AW'(`SECR_SRAM_IDLE_ADDR);
  assign sram_ce_n      = ~local_drive;
  assign sram_we_n      = ~(local_drive & d_sram_we);
  assign sram_ale_n     = ~local_drive;
  // Only the SRAM tail owns output enable, so it also tracks peer reads
  assign sram_oe_n_oe   = out_en & sram_tail;
  // Peer reads move this strobe too, so it toggles while this device is idle
  assign sram_oe_n      = ~((d_sram_req & ~d_sram_we) | peer_sram_read);

  ////////////////////////////////////////////////////////////////////////////////
  // Cascade link and data bus

  logic [1:0] casc_local_ff;
  logic [2:0] casc_block_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      casc_local_ff <= 2'h0;
      casc_block_ff <= 3'h0;
    end else begin
      casc_local_ff <= (out_en & ~in_reset) ? cascade_local_req : 2'h0;
      casc_block_ff <= (out_en & ~in_reset) ? cascade_block_req : 3'h0;
    end
  end

  // Registered, so a fresh enable reaches the link one cycle later; clearing is immediate
  assign cascade_local_out = out_en ? casc_local_ff : 2'h0;
  assign cascade_block_out = out_en ? casc_block_ff : 3'h0;
  assign dq_oe             = out_en & dq_drive_req;

endmodule : secr_command_reg

/* File: logic/_unused_guard.sv */
`timescale 1ns/10ps

/* File: test/secr_peer_model.sv */
// Purpose: Peer device on the shared SRAM bus and cascade link
// Assumes: Changes its outputs just after the rising edge
// Notes:   Fixed stride pattern, so peer traffic is spread out, at most two busy cycles in a row
`timescale 1ns/10ps
module secr_peer_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Control
  input  wire logic       go,
  // Peer side
  output logic            peer_sram_drive,
  output logic            peer_sram_read,
  output logic      [1:0] cascade_local_req,
  output logic      [2:0] cascade_block_req
);
  logic [7:0] cnt_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt_ff <= 8'h00;
    else cnt_ff <= cnt_ff + 8'h3D;
  end
  // Busy only a quarter of the time so the idle default driver is seen too
  assign peer_sram_drive   = go & (cnt_ff[7:6] == 2'h3);
  assign peer_sram_read    = go & (cnt_ff[7:5] == 3'h7);
  assign cascade_local_req = cnt_ff[1:0];
  assign cascade_block_req = cnt_ff[4:2];
endmodule : secr_peer_model

/* File: test/secr_command_reg_checker.sv */
// Purpose: Port-level assertions for the command register block
// Assumes: Bound to every instance of the register block
// Notes:   Enable state is inferred from the data bus enable
`timescale 1ns/10ps
`include "secr_defines.svh"
module secr_command_reg_checker #(
  parameter int SRAM_AW = 24
) (
  input wire logic                clk,
  input wire logic                rstn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [3:0]          pstrb,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  input wire logic                hit_flag,
  input wire logic                hit_flag_oe,
  input wire logic                hit_valid,
  input wire logic                hit_valid_oe,
  input wire logic [SRAM_AW-1:0]  sram_addr_out,
  input wire logic                sram_addr_oe,
  input wire logic                sram_ce_n,
  input wire logic                sram_we_n,
  input wire logic                sram_ale_n,
  input wire logic                sram_strobe_oe,
  input wire logic                sram_oe_n_oe,
  input wire logic                dq_drive_req,
  input wire logic                dq_oe,
  input secr_pkg::secr_part_mode_type part_mode [8],
  input wire logic [7:0]          part_sleep,
  input wire logic                soft_reset_busy
);
  import secr_pkg::*;
  logic [7:0] sleep_exp;
  for (genvar g = 0; g < 8; g++) begin : g_slp
    assign sleep_exp[g] = (part_mode[g] == SECR_PART_SLEEP);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_SOFT_RESET_BIT_LEN: assert property (
    $rose(soft_reset_busy) |-> soft_reset_busy [*8] ##1 !soft_reset_busy)
    else $error("soft reset pulse length wrong");
  AST_SOFT_RESET_BIT_GO: assert property (
    psel && penable && pwrite && paddr == `SECR_OFS_CMD_W0 && pstrb[0] && pwdata[0]
    && !soft_reset_busy |=> soft_reset_busy)
    else $error("soft reset did not start");
  AST_BAD_ADDR: assert property (psel && penable && paddr[11:4] != 8'h00 |-> pslverr)
    else $error("unmapped access without error");
  AST_RSV_READ: assert property (
    psel && penable && !pwrite && paddr == `SECR_OFS_CMD_W2 |-> prdata == 32'h0)
    else $error("reserved word read nonzero");
  AST_IDLE_BUS: assert property (
    sram_addr_oe && sram_ce_n |-> sram_addr_out == `SECR_SRAM_IDLE_ADDR && sram_we_n
    && sram_ale_n && sram_strobe_oe)
    else $error("idle SRAM bus value wrong");
  AST_OE_N_FIXED: assert property (
    !(psel && penable && pwrite) && !soft_reset_busy |=> $stable(sram_oe_n_oe))
    else $error("output enable strobe driver changed");
  AST_HIT_PAIR: assert property (
    hit_flag_oe == hit_valid_oe && (hit_valid || !hit_flag))
    else $error("hit outputs inconsistent");
  AST_DISABLED: assert property (
    dq_drive_req && !dq_oe |-> !hit_flag_oe && !sram_addr_oe && !sram_strobe_oe
    && !sram_oe_n_oe)
    else $error("disabled device drives a bus");
  AST_SLEEP: assert property (part_sleep == sleep_exp)
    else $error("sleep map wrong");
endmodule : secr_command_reg_checker
bind secr_command_reg secr_command_reg_checker #(.SRAM_AW(SRAM_AW)) u_chk (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr), .hit_flag(hit_flag),
  .hit_flag_oe(hit_flag_oe), .hit_valid(hit_valid), .hit_valid_oe(hit_valid_oe),
  .sram_addr_out(sram_addr_out), .sram_addr_oe(sram_addr_oe), .sram_ce_n(sram_ce_n),
  .sram_we_n(sram_we_n), .sram_ale_n(sram_ale_n), .sram_strobe_oe(sram_strobe_oe),
  .sram_oe_n_oe(sram_oe_n_oe), .dq_drive_req(dq_drive_req), .dq_oe(dq_oe),
  .part_mode(part_mode), .part_sleep(part_sleep), .soft_reset_busy(soft_reset_busy));

/* File: test/search_engine_command_register_tb_top.sv */
// Purpose: Self-checking bench of the command register block
// Assumes: Zero-wait APB slave; peer model on the far side
// Notes:   Config sweep covers every table size code in both speed modes
`timescale 1ns/10ps
`include "secr_defines.svh"
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; \
  $display("FAIL %s exp %0h got %0h", nm, e, s); end end
module search_engine_command_register_tb_top;
  import secr_pkg::*;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, high_speed, search_req, search_local_hit;
  logic hit_flag, hit_flag_oe, hit_valid, hit_valid_oe, sram_req, sram_we, peer_sram_drive;
  logic peer_sram_read, sram_ack, sram_addr_oe, sram_ce_n, sram_we_n, sram_ale_n, sram_strobe_oe;
  logic sram_oe_n, sram_oe_n_oe, dq_drive_req, dq_oe, soft_reset_busy, er, en, tail;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic [23:0] sram_addr, sram_addr_out;
  logic [1:0] cascade_local_req, cascade_local_out;
  logic [2:0] cascade_block_req, cascade_block_out, hd;
  logic [4:0] cs;
  logic [7:0] part_sleep;
  secr_part_mode_type part_mode [8];
  secr_part_mode_type pm;
  int mismatches, compares, n;
  secr_command_reg u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .high_speed(high_speed), .search_req(search_req),
    .search_local_hit(search_local_hit), .hit_flag(hit_flag), .hit_flag_oe(hit_flag_oe),
    .hit_valid(hit_valid), .hit_valid_oe(hit_valid_oe), .sram_req(sram_req), .sram_we(sram_we),
    .sram_addr(sram_addr), .peer_sram_drive(peer_sram_drive), .peer_sram_read(peer_sram_read),
    .sram_ack(sram_ack), .sram_addr_out(sram_addr_out), .sram_addr_oe(sram_addr_oe),
    .sram_ce_n(sram_ce_n), .sram_we_n(sram_we_n), .sram_ale_n(sram_ale_n),
    .sram_strobe_oe(sram_strobe_oe), .sram_oe_n(sram_oe_n), .sram_oe_n_oe(sram_oe_n_oe),
    .cascade_local_req(cascade_local_req), .cascade_block_req(cascade_block_req),
    .cascade_local_out(cascade_local_out), .cascade_block_out(cascade_block_out),
    .dq_drive_req(dq_drive_req), .dq_oe(dq_oe), .part_mode(part_mode), .part_sleep(part_sleep),
    .soft_reset_busy(soft_reset_busy));
  secr_peer_model u_peer (.clk(clk), .rstn(rstn), .go(1'b1), .peer_sram_drive(peer_sram_drive),
    .peer_sram_read(peer_sram_read), .cascade_local_req(cascade_local_req),
    .cascade_block_req(cascade_block_req));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) dq_drive_req <= 1'($urandom);
  task automatic test_done();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      mismatches++;
      test_done();
    end
  endtask : apb
  function automatic logic [3:0] lat(input logic h, input logic [1:0] t);
    if (t == 2'h0) return h ? 4'h5 : 4'h4;
    return (t == 2'h1) ? 4'h5 : 4'h6;
  endfunction : lat
  // Kind 0 search hit, 1 search miss, 2 SRAM write, 3 SRAM read
  task automatic probe(input int kind, input logic [3:0] exp);
    int k;
    int seen;
    logic [23:0] a;
    seen = 99;
    a = 24'($urandom);
    @(posedge clk);
    search_req <= (kind < 2);
    search_local_hit <= (kind == 0);
    sram_req <= (kind >= 2);
    sram_we <= (kind == 2);
    sram_addr <= a;
    for (k = 0; k < 20; k++) begin
      @(negedge clk);
      if (seen == 99 && ((kind < 2) ? hit_valid === 1'b1 : sram_ack === 1'b1)) seen = k;
      if (seen == k && kind < 2) `CHK("hit_flag", kind == 0, hit_flag)
      if (seen == k && kind == 2) `CHK("sram_addr_out", a, sram_addr_out)
      @(posedge clk);
      search_req <= 1'b0;
      sram_req <= 1'b0;
    end
    `CHK("latency", {4'h0, exp}, seen[7:0])
  endtask : probe
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, psel, penable, pwrite, high_speed, search_req, search_local_hit, sram_req} = '0;
    {sram_we, paddr, pwdata, sram_addr} = '0;
    n = $urandom(48);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, `SECR_OFS_CMD_W0, 32'h0);
    `CHK("cmd_w0_reset", 32'h4, rd)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped_err", 1'b1, er)
    for (int i = 0; i < 8; i++) begin
      en = (i != 5);
      tail = (i != 2);
      hd = (i == 7) ? 3'h7 : 3'($urandom_range(6, 0));
      w = $urandom;
      w[7:0] = {tail, hd, i[1:0], en, 1'b0};
      high_speed <= i[2];
      apb(1'b1, `SECR_OFS_CMD_W0, w);
      apb(1'b1, `SECR_OFS_CMD_W1, $urandom);
      apb(1'b0, `SECR_OFS_CMD_W0, 32'h0);
      `CHK("cmd_w0", w & 32'h01FFFFFF, rd)
      apb(1'b0, `SECR_OFS_CMD_W1, 32'h0);
      `CHK("cmd_w1", 32'h0, rd)
      apb(1'b1, `SECR_OFS_CMD_W2, $urandom);
      apb(1'b0, `SECR_OFS_CMD_W2, 32'h0);
      `CHK("cmd_w2", 32'h0, rd)
      for (int j = 0; j < 8; j++) begin
        pm = part_mode[j];
        `CHK("part_mode", w[9+2*j +: 2], pm)
      end
      @(negedge clk);
      cs = {cascade_local_req, cascade_block_req};
      `CHK("oe_n_oe", en & w[8], sram_oe_n_oe)
      `CHK("oe_n", ~peer_sram_read, sram_oe_n)
      `CHK("idle_addr_oe", en & w[8] & ~peer_sram_drive, sram_addr_oe)
      `CHK("idle_hit_oe", en & tail, hit_valid_oe)
      `CHK("idle_hit_valid", 1'b0, hit_valid)
      `CHK("dq_oe", en & dq_drive_req, dq_oe)
      @(negedge clk);
      `CHK("cascade_out", cs & {5{en}}, {cascade_local_out, cascade_block_out})
      for (int k = 0; k < 4 && en; k++)
        if (k != 1 || tail) probe(k, lat(i[2], i[1:0]) + ((k == 2) ? 4'h0 : {1'b0, hd}));
    end
    apb(1'b1, `SECR_OFS_CMD_W0, 32'h1);
    n = 0;
    repeat (20) begin
      @(negedge clk);
      if (soft_reset_busy === 1'b1) n++;
    end
    `CHK("busy_cycles", 8, n)
    apb(1'b0, `SECR_OFS_CMD_W0, 32'h0);
    `CHK("cmd_after_soft_reset_bit", 32'h4, rd)
    apb(1'b1, `SECR_OFS_CMD_W0, 32'h1);
    apb(1'b0, `SECR_OFS_CMD_W0, 32'h0);
    `CHK("soft_reset_bit_bit_busy", 32'h5, rd)
    apb(1'b1, `SECR_OFS_CMD_W0, 32'h2);
    repeat (10) @(posedge clk);
    apb(1'b0, `SECR_OFS_CMD_W0, 32'h0);
    `CHK("wr_while_busy", 32'h4, rd)
    apb(1'b1, `SECR_OFS_CMD_W0, 32'h2);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, `SECR_OFS_CMD_W0, 32'h0);
    `CHK("cmd_after_hwrst", 32'h4, rd)
    test_done();
  end
endmodule : search_engine_command_register_tb_top
